/* src/rxfm_top.sv */
`timescale 1ns/1ps
// Operation
// - underflow alarm on buffer read while empty
// - timestamp only first 10 underflows in log
// - overflow alarm, logged like underflow
// - AIS mode: alarm on continuous all ones
// - data mode: alarm on ones or zeros stuck
// - stuck alarm monitor only, optional relay contact
// - framing error rate above 1e-3 per 60s
// - framing error alarm requests redundancy switch-over
// - framing error alone never inserts AIS
// - synthesizer wrong frequency or unlocked alarm
// - no receive clock: alarm, use satellite clock
// - demux alarm on frame or multiframe loss
// - demux alarm replaces output with all ones
// - demux alarm requests switch-over, backward alarm
// - demux alarm whenever carrier is absent
// - alarm while 2047 test pattern unlocked
// - fill alarm below 10 or above 90 percent
// - configuration alarm on modulator/demodulator fault
module rxfm_top import rxfm_pkg::*; #(
	parameter int unsigned DEPTH = 256,
	parameter int unsigned LVLW = $clog2(DEPTH + 1),
	parameter int unsigned STUCK_LEN = STUCK_BITS,
	parameter longint unsigned FBER_WIN = FBER_WIN_CYC
) (
	input wire logic pclk, // system clock, 200 MHz
	input wire logic presetn, // async reset, active low
	input wire logic ce, // clock enable, freezes all state
	input wire logic [31:0] paddr, // apb address
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic sat_clk, // recovered satellite clock pin
	input wire logic sat_data, // demodulated satellite data pin
	input wire logic term_clk, // selected terrestrial receive clock pin
	input wire logic buf_rd_empty, // buffer read while empty, pulse
	input wire logic buf_wr_full, // buffer written while full, pulse
	input wire logic [LVLW-1:0] buf_level, // buffer occupancy
	input wire logic synth_lock, // buffer synthesizer locked
	input wire logic synth_freq_ok, // synthesizer frequency in range
	input wire logic carrier_present, // receive carrier detected
	input wire logic frame_align_ok, // demux frame alignment held
	input wire logic mframe_align_ok, // demux multiframe alignment held
	input wire logic fbit_strobe, // one framing bit decoded, pulse
	input wire logic fbit_err, // that framing bit was wrong
	input wire logic prbs_lock, // 2047 test pattern in sync
	input wire logic mod_fault, // modulator invalid state
	input wire logic demod_fault, // demodulator invalid state
	input wire logic [31:0] rtc_time, // time and date stamp
	output logic rx_out_data, // receive data toward terrestrial side
	output logic buf_clk_sat_sel, // high: buffer clock from satellite
	output logic [AL_N-1:0] alarms, // live alarm vector
	output logic receive_stuck_pattern_alarm, // stuck or AIS seen
	output logic framing_error_rate_alarm, // framing error rate
	output logic receive_clock_activity_alarm, // receive clock missing
	output logic frame_alignment_loss_alarm, // demux lost alignment
	output logic changeover_relay_contact, // relay closed on stuck
	output logic switchover_req, // redundancy switch-over request
	output logic backward_alarm // backward alarm toward distant end
);

	// ==================================================
	// pin synchronisers and edge detection
	logic [2:0] sclk_q, sdat_q, tclk_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_q <= 3'h0;
			sdat_q <= 3'h0;
			tclk_q <= 3'h0;
		end else if (ce) begin
			sclk_q <= {sclk_q[1:0], sat_clk};
			sdat_q <= {sdat_q[1:0], sat_data};
			tclk_q <= {tclk_q[1:0], term_clk};
		end
	end

	// data and clock share the same latency, so bit 1 pairs with the edge
	wire bit_stb = sclk_q[1] & ~sclk_q[2];
	wire rx_bit = sdat_q[1];
	wire tclk_edge = tclk_q[1] ^ tclk_q[2];

	// ==================================================
	// control register
	logic [2:0] ctrl_q;
	wire data_mode = ctrl_q[CTRL_DATA_MODE];
	wire relay_en = ctrl_q[CTRL_RELAY_EN];
	wire redundant = ctrl_q[CTRL_REDUNDANT];

	// ==================================================
	// apb decode
	wire [7:0] ofs = paddr[7:0];
	wire hit_ctrl = ofs == OFS_CTRL;
	wire hit_status = ofs == OFS_STATUS;
	wire hit_sticky = ofs == OFS_STICKY;
	wire hit_logcnt = ofs == OFS_LOGCNT;
	wire hit_logsel = ofs == OFS_LOGSEL;
	wire hit_logdata = ofs == OFS_LOGDATA;
	wire hit_fberr = ofs == OFS_FBERR;
	wire upper_zero = paddr[31:8] == 24'h000000;
	wire mapped = upper_zero & (hit_ctrl | hit_status | hit_sticky |
		hit_logcnt | hit_logsel | hit_logdata | hit_fberr);
	// one wait state: ready rises in the second access cycle
	wire acc = psel & penable & ~pready;
	wire done = psel & penable & pready;
	wire wr = done & pwrite & mapped;
	wire wr_ctrl = wr & hit_ctrl;
	wire wr_sticky = wr & hit_sticky;
	wire wr_logsel = wr & hit_logsel;
	wire log_clr = wr_ctrl & pwdata[CTRL_LOG_CLR];

	// ==================================================
	// stuck pattern and clock activity watchers
	logic prev_bit_q;
	wire zero_seen = bit_stb & ~rx_bit;
	wire edge_seen = bit_stb & (rx_bit != prev_bit_q);
	// AIS mode only a zero breaks the run; data mode any transition
	wire stuck_act = data_mode ? edge_seen : zero_seen;
	logic stuck_quiet, clk_quiet;

	rxfm_quiet #(
		.LIMIT(STUCK_LEN)
	) u_stuck (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.tick(bit_stb),
		.act(stuck_act),
		.quiet(stuck_quiet)
	);

	rxfm_quiet #(
		.LIMIT(ACT_CYC)
	) u_clkact (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.tick(1'b1),
		.act(tclk_edge),
		.quiet(clk_quiet)
	);

	// ==================================================
	// framing bit error rate over the measurement window
	logic [63:0] win_q;
	logic [31:0] fbits_q, ferrs_q, ferrs_last_q;
	logic fber_q;
	wire win_end = win_q == (FBER_WIN - 64'd1);
	wire [41:0] err_scaled = {10'h000, ferrs_q} * 42'(FBER_RATIO);
	wire fber_over = err_scaled > {10'h000, fbits_q};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_q <= 64'h0;
			fbits_q <= 32'h0;
			ferrs_q <= 32'h0;
			ferrs_last_q <= 32'h0;
			fber_q <= 1'b0;
		end else if (ce) begin
			if (win_end) begin
				win_q <= 64'h0;
				fbits_q <= 32'h0;
				ferrs_q <= 32'h0;
				ferrs_last_q <= ferrs_q;
				fber_q <= fber_over;
			end else begin
				win_q <= win_q + 64'd1;
				if (fbit_strobe) begin
					fbits_q <= fbits_q + 32'd1;
					ferrs_q <= ferrs_q + {31'h0, fbit_err};
				end
			end
		end
	end

	// ==================================================
	// live fault conditions
	// compare in percent so a depth not divisible by 100 keeps exact limits
	wire [31:0] lvl_pct = 32'(buf_level) * 32'd100;
	wire fill_bad = (lvl_pct < 32'(DEPTH * FILL_LO_PCT)) |
		(lvl_pct > 32'(DEPTH * FILL_HI_PCT));
	wire synth_bad = ~synth_lock | ~synth_freq_ok;
	wire align_lost = ~frame_align_ok | ~mframe_align_ok;
	wire demux_bad = ~carrier_present | align_lost;
	wire cfg_bad = mod_fault | demod_fault;

	logic [AL_N-1:0] al_d;
	always_comb begin
		al_d = AL_RST;
		al_d[AL_UNDER] = buf_rd_empty;
		al_d[AL_OVER] = buf_wr_full;
		al_d[AL_STUCK] = stuck_quiet;
		al_d[AL_FBER] = fber_q;
		al_d[AL_SYNTH] = synth_bad;
		al_d[AL_CLKACT] = clk_quiet;
		al_d[AL_DEMUX] = demux_bad;
		al_d[AL_PRBS] = ~prbs_lock;
		al_d[AL_FILL] = fill_bad;
		al_d[AL_CONFIG] = cfg_bad;
	end

	// only the demux alarm (carrier or alignment loss) forces AIS; framing errors alone never do
	wire ais_ins = demux_bad;
	wire prompt = fber_q | demux_bad;

	// ==================================================
	// alarm registers and outputs
	logic [AL_N-1:0] al_q, sticky_q;
	logic out_q, clksel_q, relay_q, swo_q, bwd_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			al_q <= AL_RST;
			sticky_q <= AL_RST;
			out_q <= 1'b1;
			clksel_q <= 1'b0;
			relay_q <= 1'b0;
			swo_q <= 1'b0;
			bwd_q <= 1'b0;
			prev_bit_q <= 1'b0;
		end else if (ce) begin
			al_q <= al_d;
			// a new event in the clearing cycle stays set
			sticky_q <= (sticky_q & ~({AL_N{wr_sticky}} &
				pwdata[AL_N-1:0])) | al_d;
			if (bit_stb) begin
				prev_bit_q <= rx_bit;
			end
			// AIS takes over at once, not at the next bit strobe
			if (ais_ins) begin
				out_q <= 1'b1;
			end else if (bit_stb) begin
				// data passes untouched otherwise
				out_q <= rx_bit;
			end
			clksel_q <= clk_quiet;
			relay_q <= relay_en & stuck_quiet;
			swo_q <= redundant & prompt;
			bwd_q <= demux_bad;
		end
	end

	assign alarms = al_q;
	assign rx_out_data = out_q;
	assign buf_clk_sat_sel = clksel_q;
	assign receive_stuck_pattern_alarm = al_q[AL_STUCK];
	assign framing_error_rate_alarm = al_q[AL_FBER];
	assign receive_clock_activity_alarm = al_q[AL_CLKACT];
	assign frame_alignment_loss_alarm = al_q[AL_DEMUX];
	assign changeover_relay_contact = relay_q;
	assign switchover_req = swo_q;
	assign backward_alarm = bwd_q;

	// ==================================================
	// event log: first entries of each kind, contents kept over reset
	logic [31:0] log_mem [0:2*LOG_DEPTH-1];
	logic [LOG_CW-1:0] ucnt_q, ocnt_q;
	logic [LOG_AW-1:0] logsel_q;
	wire under_log = buf_rd_empty & (ucnt_q < LOG_CW'(LOG_DEPTH));
	wire over_log = buf_wr_full & (ocnt_q < LOG_CW'(LOG_DEPTH));
	wire [LOG_AW-1:0] u_addr = {1'b0, ucnt_q};
	wire [LOG_AW-1:0] o_addr = LOG_AW'(LOG_DEPTH) + {1'b0, ocnt_q};
	wire sel_ok = logsel_q < LOG_AW'(2 * LOG_DEPTH);

	// memory has no reset: it stands in for battery-retained storage
	always_ff @(posedge pclk) begin
		if (ce) begin
			if (under_log) begin
				log_mem[u_addr] <= rtc_time;
			end
			if (over_log) begin
				log_mem[o_addr] <= rtc_time;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ucnt_q <= '0;
			ocnt_q <= '0;
			logsel_q <= '0;
			ctrl_q <= CTRL_RST;
		end else if (ce) begin
			if (log_clr) begin
				ucnt_q <= '0;
				ocnt_q <= '0;
			end else begin
				if (under_log) begin
					ucnt_q <= ucnt_q + 1'b1;
				end
				if (over_log) begin
					ocnt_q <= ocnt_q + 1'b1;
				end
			end
			if (wr_ctrl) begin
				ctrl_q <= pwdata[2:0];
			end
			if (wr_logsel) begin
				logsel_q <= pwdata[LOG_AW-1:0];
			end
		end
	end

	// ==================================================
	// apb read path and handshake
	wire [31:0] log_word = sel_ok ? log_mem[logsel_q] : 32'h00000000;
	wire [31:0] rd_ctrl = {29'h0, ctrl_q};
	wire [31:0] rd_status = {{(32-AL_N){1'b0}}, al_q};
	wire [31:0] rd_sticky = {{(32-AL_N){1'b0}}, sticky_q};
	wire [31:0] rd_logcnt = {8'h00, 4'h0, ocnt_q, 12'h000, ucnt_q};
	wire [31:0] rd_logsel = {{(32-LOG_AW){1'b0}}, logsel_q};
	wire [31:0] rd_mux =
		hit_ctrl ? rd_ctrl :
		hit_status ? rd_status :
		hit_sticky ? rd_sticky :
		hit_logcnt ? rd_logcnt :
		hit_logsel ? rd_logsel :
		hit_logdata ? log_word :
		hit_fberr ? ferrs_last_q : 32'h00000000;
	wire [31:0] rd_val = (mapped & ~pwrite) ? rd_mux : 32'h00000000;

	logic rdy_q, err_q;
	logic [31:0] rdata_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdy_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end else if (ce) begin
			rdy_q <= acc;
			// error flop rises and falls with ready, so it drives the pin
			err_q <= acc & ~mapped;
			if (acc) begin
				rdata_q <= rd_val;
			end else if (done) begin
				rdata_q <= 32'h00000000;
			end
		end
	end

	assign pready = rdy_q;
	assign pslverr = err_q;
	assign prdata = rdata_q;
endmodule

/* src/rxfm_pkg.sv */
package rxfm_pkg;

	// ==================================================
	// clock and timing
	localparam int unsigned CLK_NS = 5;
	localparam longint unsigned CLK_HZ = 64'd200_000_000;
	localparam longint unsigned FBER_WIN_S = 64'd60;
	localparam longint unsigned FBER_WIN_CYC = FBER_WIN_S * CLK_HZ;
	// receive clock declared absent after this long without an edge
	localparam int unsigned ACT_TO_NS = 2000;
	localparam int unsigned ACT_CYC = (ACT_TO_NS + CLK_NS - 1) / CLK_NS;
	// received bits without a zero (AIS mode) or a transition (data mode) before stuck is declared
	localparam int unsigned STUCK_BITS = 1024;
	// framing error threshold: one in this many
	localparam int unsigned FBER_RATIO = 1000;

	// ==================================================
	// buffer fill limits and event log
	localparam int unsigned FILL_LO_PCT = 10;
	localparam int unsigned FILL_HI_PCT = 90;
	localparam int unsigned LOG_DEPTH = 10;
	localparam int unsigned LOG_CW = 4;
	localparam int unsigned LOG_AW = 5;

	// ==================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_STICKY = 8'h08;
	localparam logic [7:0] OFS_LOGCNT = 8'h0C;
	localparam logic [7:0] OFS_LOGSEL = 8'h10;
	localparam logic [7:0] OFS_LOGDATA = 8'h14;
	localparam logic [7:0] OFS_FBERR = 8'h18;

	// ==================================================
	// control fields and reset value
	localparam int unsigned CTRL_DATA_MODE = 0;
	localparam int unsigned CTRL_RELAY_EN = 1;
	localparam int unsigned CTRL_REDUNDANT = 2;
	localparam int unsigned CTRL_LOG_CLR = 3;
	localparam logic [2:0] CTRL_RST = 3'h4;

	// ==================================================
	// alarm vector bit positions
	localparam int unsigned AL_UNDER = 0;
	localparam int unsigned AL_OVER = 1;
	localparam int unsigned AL_STUCK = 2;
	localparam int unsigned AL_FBER = 3;
	localparam int unsigned AL_SYNTH = 4;
	localparam int unsigned AL_CLKACT = 5;
	localparam int unsigned AL_DEMUX = 6;
	localparam int unsigned AL_PRBS = 7;
	localparam int unsigned AL_FILL = 8;
	localparam int unsigned AL_CONFIG = 9;
	localparam int unsigned AL_N = 10;
	localparam logic [AL_N-1:0] AL_RST = 10'h000;

endpackage

/* src/rxfm_quiet.sv */
`timescale 1ns/1ps
// counts ticks since the last activity; quiet once the count hits LIMIT
module rxfm_quiet #(
	parameter int unsigned LIMIT = 16,
	parameter int unsigned CW = $clog2(LIMIT + 1)
) (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic ce, // clock enable
	input wire logic tick, // one observation step
	input wire logic act, // activity seen this cycle
	output logic quiet // no activity for LIMIT ticks
);
	logic [CW-1:0] cnt_q;
	localparam logic [CW-1:0] LIM = CW'(LIMIT);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else if (ce) begin
			if (act) begin
				cnt_q <= '0;
			end else if (tick && cnt_q != LIM) begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	assign quiet = (cnt_q == LIM);
endmodule

/* dv/rxfm_monitor.sv */
`timescale 1ns/1ps
module rxfm_monitor import rxfm_pkg::*; #(
	parameter int unsigned DEPTH = 256,
	parameter int unsigned LVLW = 9
) (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic ce, // enable
	input wire logic buf_rd_empty, // underflow
	input wire logic buf_wr_full, // overflow
	input wire logic [LVLW-1:0] buf_level, // fill
	input wire logic synth_lock, // locked
	input wire logic synth_freq_ok, // freq ok
	input wire logic carrier_present, // carrier
	input wire logic frame_align_ok, // frame
	input wire logic mframe_align_ok, // multiframe
	input wire logic prbs_lock, // pattern sync
	input wire logic mod_fault, // mod fault
	input wire logic demod_fault, // demod fault
	input wire logic rx_out_data, // data out
	input wire logic buf_clk_sat_sel, // fallback
	input wire logic [AL_N-1:0] alarms, // alarms
	input wire logic receive_clock_activity_alarm, // no clock
	input wire logic frame_alignment_loss_alarm, // demux
	input wire logic backward_alarm // backward
);
	// ==================================================
	// helpers
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire fill_bad = (buf_level * 100 < DEPTH * 10)
		|| (buf_level * 100 > DEPTH * 90);
	wire demux_bad = !carrier_present || !frame_align_ok
		|| !mframe_align_ok;
	wire clk_lost = receive_clock_activity_alarm;
	wire dmx = frame_alignment_loss_alarm;
	// ==================================================
	// checks
	AST_UNDER: assert property (ce && buf_rd_empty |=> alarms[AL_UNDER])
		else $error("underflow alarm missing");
	AST_OVER: assert property (ce && buf_wr_full |=> alarms[AL_OVER])
		else $error("overflow alarm missing");
	AST_SYNTH: assert property (ce |=> alarms[AL_SYNTH] ==
		$past(!(synth_lock && synth_freq_ok)))
		else $error("synth alarm wrong");
	AST_DEMUX: assert property (ce |=> alarms[AL_DEMUX] ==
		$past(demux_bad)) else $error("demux alarm wrong");
	AST_PRBS: assert property (ce |=> alarms[AL_PRBS] ==
		$past(!prbs_lock)) else $error("pattern alarm wrong");
	AST_FILL: assert property (ce |=> alarms[AL_FILL] ==
		$past(fill_bad)) else $error("fill alarm wrong");
	AST_CONFIG: assert property (ce |=> alarms[AL_CONFIG] ==
		$past(mod_fault || demod_fault)) else $error("config alarm wrong");
	AST_AIS: assert property (dmx && $past(dmx) |-> rx_out_data)
		else $error("ais not inserted");
	AST_FALLBACK: assert property (clk_lost && $past(clk_lost)
		|-> buf_clk_sat_sel) else $error("no clock fallback");
	AST_BACK: assert property (backward_alarm == dmx)
		else $error("backward alarm wrong");
endmodule

bind rxfm_top rxfm_monitor #(.DEPTH(DEPTH), .LVLW(LVLW)) u_mon (
	.pclk, .presetn, .ce, .buf_rd_empty, .buf_wr_full, .buf_level,
	.synth_lock, .synth_freq_ok, .carrier_present, .frame_align_ok,
	.mframe_align_ok, .prbs_lock, .mod_fault, .demod_fault,
	.rx_out_data, .buf_clk_sat_sel, .alarms,
	.receive_clock_activity_alarm, .frame_alignment_loss_alarm,
	.backward_alarm
);

/* dv/rxfm_sat_model.sv */
`timescale 1ns/1ps
module rxfm_sat_model (
	input wire logic run, // satellite clock runs
	input wire logic [1:0] pat, // 0 toggle, 1 ones, 2 zeros
	input wire logic term_run, // terrestrial clock runs
	output logic sat_clk, // recovered clock
	output logic sat_data, // demodulated data
	output logic term_clk // terrestrial clock
);
	logic bit_q = 1'b0;
	// data moves on the falling edge, far from the sampling rise
	initial begin
		sat_clk = 1'b0;
		sat_data = 1'b0;
		#7.3;
		forever begin
			#62.5;
			sat_clk = run;
			#62.5;
			sat_clk = 1'b0;
			bit_q = !bit_q;
			sat_data = (pat == 2'h0) ? bit_q : (pat == 2'h1);
		end
	end
	// stands still when stopped, so the activity alarm can trip
	initial begin
		term_clk = 1'b0;
		#21.1;
		forever begin
			#62.5;
			term_clk = term_run ? !term_clk : term_clk;
		end
	end
endmodule

/* dv/rxfm_top_tb.sv */
`timescale 1ns/1ps
module rxfm_top_tb import rxfm_pkg::*; ();
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, rtc_time, rd;
	logic sat_clk, sat_data, term_clk, term_run, serr;
	logic buf_rd_empty, buf_wr_full, fbit_strobe, fbit_err;
	logic [6:0] buf_level;
	logic synth_lock, synth_freq_ok, carrier_present, frame_align_ok;
	logic mframe_align_ok, prbs_lock, mod_fault, demod_fault;
	logic rx_out_data, buf_clk_sat_sel, stuck, fber, clkact, demux;
	logic relay, sw_req, back;
	// far end equipment folds the framing alarm into its backward alarm
	wire ext_bwd = back | fber;
	logic [AL_N-1:0] alarms;
	logic [1:0] pat;
	int n_fail = 0;
	int checks_done = 0;
	int i;
	typedef struct packed {
		logic [7:0] in;
		logic [6:0] lvl;
		logic [9:0] al;
	} rxfm_row_t;
	// in: synth lock, freq, carrier, frame, mframe, prbs, mod, demod
	rxfm_row_t rows [13] = '{
		'{8'hFC, 7'h32, 10'h000}, '{8'h7C, 7'h32, 10'h010},
		'{8'hBC, 7'h32, 10'h010}, '{8'hDC, 7'h32, 10'h040},
		'{8'hEC, 7'h32, 10'h040}, '{8'hF4, 7'h32, 10'h040},
		'{8'hF8, 7'h32, 10'h080}, '{8'hFE, 7'h32, 10'h200},
		'{8'hFD, 7'h32, 10'h200}, '{8'hFC, 7'h09, 10'h100},
		'{8'hFC, 7'h0A, 10'h000}, '{8'hFC, 7'h5A, 10'h000},
		'{8'hFC, 7'h5B, 10'h100}};
	// depth 100 makes the fill limits whole levels
	// a 2001-cycle window counts 2000 framing bits
	rxfm_top #(.DEPTH(100), .STUCK_LEN(16), .FBER_WIN(2001)) DUT (
		.pclk, .presetn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .sat_clk, .sat_data, .term_clk,
		.buf_rd_empty, .buf_wr_full, .buf_level, .synth_lock,
		.synth_freq_ok, .carrier_present, .frame_align_ok,
		.mframe_align_ok, .fbit_strobe, .fbit_err, .prbs_lock,
		.mod_fault, .demod_fault, .rtc_time, .rx_out_data,
		.buf_clk_sat_sel, .alarms, .receive_stuck_pattern_alarm(stuck),
		.framing_error_rate_alarm(fber),
		.receive_clock_activity_alarm(clkact),
		.frame_alignment_loss_alarm(demux),
		.changeover_relay_contact(relay), .switchover_req(sw_req),
		.backward_alarm(back));
	rxfm_sat_model u_sat (.run(1'b1), .pat, .term_run, .sat_clk,
		.sat_data, .term_clk);
	// ==================================================
	// tasks
	task automatic results();
		$display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		int k;
		psel <= 1'b1;
		paddr <= {24'h000000, a};
		pwrite <= wr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 50) begin
			n_fail++;
			results();
		end
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_al(input int b, input logic v, input int n);
		int k;
		for (k = 0; k < n; k++) begin
			@(posedge pclk);
			if (alarms[b] === v) break;
		end
		if (k == n) begin
			n_fail++;
			results();
		end
	endtask
	task automatic fber_run(input int per, input int n, input logic lo);
		int k;
		for (k = 0; k < n; k++) begin
			fbit_err <= (k % per == 0);
			@(posedge pclk);
			if (lo) chk(fber, 1'b0);
		end
	endtask
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// ==================================================
	// sequence
	initial begin
		{presetn, psel, penable, pwrite, buf_rd_empty, buf_wr_full} = 6'h00;
		{fbit_strobe, fbit_err, mod_fault, demod_fault} = 4'h0;
		{synth_lock, synth_freq_ok, carrier_present} = 3'h7;
		{frame_align_ok, mframe_align_ok, prbs_lock} = 3'h7;
		{ce, term_run, pat, buf_level} = {2'h3, 2'h0, 7'h32};
		{paddr, pwdata, rtc_time} = {32'h0, 32'h0, 32'h0};
		repeat (12) @(posedge pclk);
		chk(alarms, 10'h000);
		chk(rx_out_data, 1'b1);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rd, CTRL_RST);
		apb(1'b1, 8'h20, 32'h5);
		chk(serr, 1'b1);
		apb(1'b0, 8'h20, 32'h0);
		chk({serr, rd}, {1'b1, 32'h0});
		foreach (rows[j]) begin
			{synth_lock, synth_freq_ok, carrier_present, frame_align_ok,
				mframe_align_ok, prbs_lock, mod_fault, demod_fault} <= rows[j].in;
			buf_level <= rows[j].lvl;
			repeat (4) @(posedge pclk);
			chk(alarms, rows[j].al);
			chk({sw_req, back, demux}, {3{rows[j].al[AL_DEMUX]}});
			if (rows[j].al[AL_DEMUX]) chk(rx_out_data, 1'b1);
			apb(1'b0, OFS_STATUS, 32'h0);
			chk(rd, rows[j].al);
		end
		// events: 12 underflows, then 3 overflows; the first 10 underflows and all overflows stamped
		for (i = 0; i < 15; i++) begin
			rtc_time <= 32'hA000_0000 + i;
			buf_rd_empty <= (i < 12);
			buf_wr_full <= (i >= 12);
			@(posedge pclk);
			{buf_rd_empty, buf_wr_full} <= 2'h0;
			@(posedge pclk);
			chk(alarms[i < 12 ? AL_UNDER : AL_OVER], 1'b1);
			@(posedge pclk);
		end
		// latched alarms; the live fill fault survives its own clear
		apb(1'b0, OFS_STICKY, 32'h0);
		chk(rd, 32'h0000_03D3);
		apb(1'b1, OFS_STICKY, 32'h3FF);
		apb(1'b0, OFS_STICKY, 32'h0);
		chk(rd, 32'h0000_0100);
		apb(1'b0, OFS_LOGCNT, 32'h0);
		chk(rd, 32'h0003_000A);
		apb(1'b1, OFS_LOGSEL, 32'h9);
		apb(1'b0, OFS_LOGDATA, 32'h0);
		chk(rd, 32'hA000_0009);
		apb(1'b1, OFS_LOGSEL, 32'hA);
		apb(1'b0, OFS_LOGDATA, 32'h0);
		chk(rd, 32'hA000_000C);
		apb(1'b1, OFS_CTRL, 32'hC);
		apb(1'b0, OFS_LOGCNT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk(rd, 32'h4);
		// mid-run reset: log contents are retained
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, OFS_LOGDATA, 32'h0);
		chk(rd, 32'hA000_0000);
		// stuck ones, ais mode
		pat <= 2'h1;
		repeat (200) @(posedge pclk);
		chk(stuck, 1'b0);
		wait_al(AL_STUCK, 1'b1, 1500);
		chk(relay, 1'b0);
		apb(1'b1, OFS_CTRL, 32'h6);
		@(posedge pclk);
		chk(relay, 1'b1);
		pat <= 2'h2;
		repeat (600) @(posedge pclk);
		chk({stuck, rx_out_data}, 2'h0);
		apb(1'b1, OFS_CTRL, 32'h7);
		wait_al(AL_STUCK, 1'b1, 1500);
		pat <= 2'h0;
		wait_al(AL_STUCK, 1'b0, 100);
		// receive clock loss
		term_run <= 1'b0;
		repeat (380) @(posedge pclk);
		chk(clkact, 1'b0);
		wait_al(AL_CLKACT, 1'b1, 600);
		chk(buf_clk_sat_sel, 1'b1);
		term_run <= 1'b1;
		wait_al(AL_CLKACT, 1'b0, 100);
		// framing errors: exactly 1e-3 stays quiet, twice that trips
		pat <= 2'h2;
		fbit_strobe <= 1'b1;
		repeat (4100) @(posedge pclk);
		fber_run(1000, 6000, 1'b1);
		fber_run(500, 5000, 1'b0);
		chk(fber, 1'b1);
		chk(sw_req, 1'b1);
		chk(rx_out_data, 1'b0);
		chk(ext_bwd, 1'b1);
		results();
	end
endmodule
